// *** hdl/uasi_pkg.sv ***
/*
 * Shared constants for the USB attach and status interrupt block.
 * Assumes a single 100 MHz clock and a 32-bit Avalon-MM register port.
 */
package uasi_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int SAMPLE_MS = 20;
	localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int STARTUP_MS = 5;
	localparam int STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
	localparam int I2C_KHZ = 100;
	localparam int I2C_HALF_CYC = CLK_HZ / (2 * I2C_KHZ * 1000);
	localparam int CNT_W = 24;
	localparam int GPIO_W = 6;
	localparam int EV_W = 4;
	localparam int ADR_W = 5;

	localparam logic [4:0] ADR_CFG8 = 5'h00;
	localparam logic [4:0] ADR_CFG9 = 5'h04;
	localparam logic [4:0] ADR_GPOUT = 5'h08;
	localparam logic [4:0] ADR_STAT = 5'h0C;
	localparam logic [4:0] ADR_IRQ_ST = 5'h10;
	localparam logic [4:0] ADR_IRQ_CLR = 5'h14;
	localparam logic [4:0] ADR_IRQ_EN = 5'h18;
	localparam logic [4:0] ADR_REPORT = 5'h1C;

	localparam int CFG8_MEDIA_EN = 0;
	localparam int CFG8_ATA_ALWAYS = 4;
	localparam int CFG8_PU_GPIN = 7;
	localparam logic [7:0] CFG8_RST = 8'h00;
	localparam logic [5:0] CFG9_RST = 6'h3F;
	localparam logic [5:0] GPOUT_RST = 6'h00;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;

	localparam int RPT_PU_BIT = 2;
	localparam int RPT_BP_BIT = 8;
	localparam int RPT_HS_BIT = 9;

	localparam int EV_SREQ = 0;
	localparam int EV_SENT = 1;
	localparam int EV_NAK = 2;
	localparam int EV_VBUS = 3;

	localparam int ST_PEND = 0;
	localparam int ST_PULLUP = 1;
	localparam int ST_VBUS = 2;
	localparam int ST_I2C = 3;
	localparam int ST_READY = 4;
	localparam int ST_ATA_ACT = 5;
endpackage

// *** hdl/uasi_tmr_if.sv ***
/*
 * Carries startup and sampling state from the timer to the main block.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface uasi_tmr_if;
	logic ready;
	logic vbus_smp;
	logic smp_tick;
	logic scl_low;
	modport timer (output ready, output vbus_smp, output smp_tick, output scl_low);
	modport user (input ready, input vbus_smp, input smp_tick, input scl_low);
endinterface
`default_nettype wire

// *** hdl/uasi_timer.sv ***
/*
 * Startup interval, configuration clock phase and periodic enable sampling.
 * Assumes inputs synchronous to ref_clk and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module uasi_timer #(
	parameter int STARTUP_CYC = uasi_pkg::STARTUP_CYC,
	parameter int SAMPLE_CYC = uasi_pkg::SAMPLE_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic bus_power_ata_enable_in,
	uasi_tmr_if.timer t
);
	localparam logic [uasi_pkg::CNT_W-1:0] START_LAST = uasi_pkg::CNT_W'(STARTUP_CYC - 1);
	localparam logic [uasi_pkg::CNT_W-1:0] SMP_LAST = uasi_pkg::CNT_W'(SAMPLE_CYC - 1);
	localparam logic [uasi_pkg::CNT_W-1:0] HALF_LAST =
		uasi_pkg::CNT_W'(uasi_pkg::I2C_HALF_CYC - 1);

	logic [uasi_pkg::CNT_W-1:0] cnt_reg;
	logic [uasi_pkg::CNT_W-1:0] half_reg;
	logic ready_reg;
	logic vbus_reg;
	logic scl_low_reg;
	logic tick_reg;

	wire cnt_end = ready_reg ? (cnt_reg == SMP_LAST) : (cnt_reg == START_LAST);
	wire half_end = half_reg == HALF_LAST;

	// Enable is taken once at the end of startup, then every sample period. [RQ16]
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_reg <= '0;
			ready_reg <= 1'b0;
			vbus_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_end ? '0 : cnt_reg + 1'b1;
			tick_reg <= cnt_end;
			if (cnt_end) begin
				ready_reg <= 1'b1;
				vbus_reg <= bus_power_ata_enable_in;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			half_reg <= '0;
			scl_low_reg <= 1'b0;
		end else begin
			half_reg <= half_end ? '0 : half_reg + 1'b1;
			if (half_end)
				scl_low_reg <= ~scl_low_reg;
		end
	end

	assign t.ready = ready_reg;
	assign t.vbus_smp = vbus_reg;
	assign t.smp_tick = tick_reg;
	assign t.scl_low = scl_low_reg;
endmodule // uasi_timer
`default_nettype wire

// *** hdl/uasi_top.sv ***
/*
 * USB attach gating and endpoint 1 status report with an Avalon-MM register port.
 * Assumes all inputs synchronous to ref_clk; the USB engine pulses ep1_poll per IN poll.
 */
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RQ1) Config byte 8 bit 7 set turns the ATA pull-up control pin into an input.
// (RQ2) In input mode, that pin's level is reported in report byte 0 bit 2.
// (RQ3) Config byte 8 bit 4 zero: ATA pins active only while enable is sampled high.
// (RQ4) After reset, pull-up gating uses enable, media-detect enable bit and drive detect.
// (RQ5) Pull-up on only when enable is 1 and drive detected or media bit is 1.
// (RQ6) I2C lines driven only during the startup interval, idle afterwards.
// (RQ7) The system supplies one reference clock for all timing.
// (RQ8) Endpoint 1 polls are NAKed while no report is pending.
// (RQ9) With a report pending, a poll returns the 16-bit two-byte report.
// (RQ10) Report byte 1: bit 1 high speed, bit 0 bus powered, rest reserved.
// (RQ11) Report byte 0: GPIO 5..0 in bits 5..0, bits 7 and 6 reserved.
// (RQ12) GPIO not configured as input reports zero.
// (RQ13) Each GPIO direction is set individually from config byte 0x09.
// (RQ14) Service request makes a report pending for the next poll.
// (RQ15) The system holds service request low when button reporting is used.
// (RQ16) The enable input is sampled at startup and every 20 ms after.
// (RQ17) A sampled enable of zero releases the D+ pull-up.
// (RQ18) Returning a report clears the pending flag.
module uasi_top #(
	parameter int STARTUP_CYC = uasi_pkg::STARTUP_CYC,
	parameter int SAMPLE_CYC = uasi_pkg::SAMPLE_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic bus_power_ata_enable_in,
	input wire logic ata_drive_detected,
	input wire logic usb_high_speed,
	input wire logic usb_bus_powered,
	input wire logic service_request_in,
	input wire logic ata_bus_busy,
	input wire logic [5:0] gpio_in,
	output logic [5:0] gpio_out,
	output logic [5:0] gpio_oe,
	input wire logic ata_pullup_ctrl_in,
	output logic ata_pullup_ctrl_out,
	output logic ata_pullup_ctrl_oe,
	output logic ata_pins_active,
	output logic usb_dp_pullup,
	input wire logic i2c_scl_in,
	output logic i2c_scl_out,
	output logic i2c_scl_oe,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	input wire logic ep1_poll,
	output logic ep1_ack,
	output logic ep1_nak,
	output logic [15:0] ep1_data
);
	uasi_tmr_if tmr ();

	uasi_timer #(
		.STARTUP_CYC(STARTUP_CYC),
		.SAMPLE_CYC(SAMPLE_CYC)
	) u_timer (
		.ref_clk(ref_clk),
		.srst(srst),
		.bus_power_ata_enable_in(bus_power_ata_enable_in),
		.t(tmr.timer)
	);

	logic [7:0] cfg8_reg;
	logic [5:0] cfg9_reg;
	logic [5:0] gpout_reg;
	logic [3:0] irq_st_reg;
	logic [3:0] irq_st_next;
	logic [3:0] irq_en_reg;
	logic pend_reg;
	logic pend_next;
	logic vbus_d_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ep1_ack_reg;
	logic ep1_nak_reg;
	logic [15:0] ep1_data_reg;
	logic [15:0] last_rpt_reg;

	// Register port: one wait state, the access completes on the second edge.
	wire req = avs_read | avs_write;
	wire done = req & ack_reg;
	wire wr_done = avs_write & ack_reg;
	wire hit_cfg8 = avs_address == uasi_pkg::ADR_CFG8;
	wire hit_cfg9 = avs_address == uasi_pkg::ADR_CFG9;
	wire hit_gpout = avs_address == uasi_pkg::ADR_GPOUT;
	wire hit_stat = avs_address == uasi_pkg::ADR_STAT;
	wire hit_irq_st = avs_address == uasi_pkg::ADR_IRQ_ST;
	wire hit_irq_clr = avs_address == uasi_pkg::ADR_IRQ_CLR;
	wire hit_irq_en = avs_address == uasi_pkg::ADR_IRQ_EN;
	wire hit_report = avs_address == uasi_pkg::ADR_REPORT;

	wire pu_gpin = cfg8_reg[uasi_pkg::CFG8_PU_GPIN];
	wire media_en = cfg8_reg[uasi_pkg::CFG8_MEDIA_EN];
	wire ata_always = cfg8_reg[uasi_pkg::CFG8_ATA_ALWAYS];

	// Pull-up held off until startup completes, then gated by the sampled enable.
	wire dp_pullup = tmr.ready & tmr.vbus_smp & (ata_drive_detected | media_en); // [RQ4] [RQ5] [RQ17]
	wire ata_act = ata_always | tmr.vbus_smp; // [RQ3]

	// Report assembly; reserved bits are zero.
	logic [15:0] report;
	genvar gi;
	generate
		for (gi = 0; gi < uasi_pkg::GPIO_W; gi++) begin : g_gpio
			// A 1 in a pin's bit of the direction byte marks an input; outputs report zero.
			wire gpio_bit = cfg9_reg[gi] & gpio_in[gi]; // [RQ12] [RQ13]
			if (gi == uasi_pkg::RPT_PU_BIT) begin : g_pu
				assign report[gi] = pu_gpin ? ata_pullup_ctrl_in : gpio_bit; // [RQ2]
			end else begin : g_plain
				assign report[gi] = gpio_bit; // [RQ11]
			end
			assign gpio_oe[gi] = ~cfg9_reg[gi]; // [RQ13]
		end
	endgenerate
	assign report[7:6] = 2'b00; // [RQ11]
	assign report[uasi_pkg::RPT_BP_BIT] = usb_bus_powered; // [RQ10]
	assign report[uasi_pkg::RPT_HS_BIT] = usb_high_speed; // [RQ10]
	assign report[15:10] = 6'h00; // [RQ10]

	// A poll is answered with data only while a report is pending.
	wire send = ep1_poll & pend_reg; // [RQ9]
	wire nak = ep1_poll & ~pend_reg; // [RQ8]

	// Service request wins over the clear from a returned report.
	assign pend_next = service_request_in | (pend_reg & ~send); // [RQ14] [RQ18]

	wire [3:0] events;
	assign events[uasi_pkg::EV_SREQ] = service_request_in & ~pend_reg;
	assign events[uasi_pkg::EV_SENT] = send;
	assign events[uasi_pkg::EV_NAK] = nak;
	assign events[uasi_pkg::EV_VBUS] = tmr.smp_tick & (tmr.vbus_smp ^ vbus_d_reg);

	wire [3:0] clr = (wr_done & hit_irq_clr) ? avs_writedata[3:0] : 4'h0;
	assign irq_st_next = (irq_st_reg & ~clr) | events;

	wire [5:0] stat = {ata_act, tmr.ready, ~tmr.ready, tmr.vbus_smp, dp_pullup, pend_reg};

	assign rdata_next =
		hit_cfg8 ? {24'h000000, cfg8_reg} :
		hit_cfg9 ? {26'h0000000, cfg9_reg} :
		hit_gpout ? {26'h0000000, gpout_reg} :
		hit_stat ? {26'h0000000, stat} :
		hit_irq_st ? {28'h0000000, irq_st_reg} :
		hit_irq_en ? {28'h0000000, irq_en_reg} :
		hit_report ? {16'h0000, last_rpt_reg} :
		32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (avs_read & ~ack_reg)
				rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg8_reg <= uasi_pkg::CFG8_RST;
			cfg9_reg <= uasi_pkg::CFG9_RST;
			gpout_reg <= uasi_pkg::GPOUT_RST;
			irq_en_reg <= uasi_pkg::IRQ_EN_RST;
		end else if (wr_done) begin
			if (hit_cfg8)
				cfg8_reg <= avs_writedata[7:0]; // [RQ1] [RQ3]
			else if (hit_cfg9)
				cfg9_reg <= avs_writedata[5:0]; // [RQ13]
			else if (hit_gpout)
				gpout_reg <= avs_writedata[5:0];
			else if (hit_irq_en)
				irq_en_reg <= avs_writedata[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend_reg <= 1'b0;
			irq_st_reg <= 4'h0;
			vbus_d_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			irq_st_reg <= irq_st_next;
			if (tmr.smp_tick)
				vbus_d_reg <= tmr.vbus_smp;
		end
	end

	// Answer strobes and data are registered one edge after the poll.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ep1_ack_reg <= 1'b0;
			ep1_nak_reg <= 1'b0;
			ep1_data_reg <= 16'h0000;
			last_rpt_reg <= 16'h0000;
		end else begin
			ep1_ack_reg <= send; // [RQ9]
			ep1_nak_reg <= nak; // [RQ8]
			if (send) begin
				ep1_data_reg <= report; // [RQ9]
				last_rpt_reg <= report;
			end
		end
	end

	assign avs_waitrequest = req & ~ack_reg;
	assign avs_readdata = rdata_reg;
	assign irq = |(irq_st_reg & irq_en_reg);
	assign ep1_ack = ep1_ack_reg;
	assign ep1_nak = ep1_nak_reg;
	assign ep1_data = ep1_data_reg;
	assign gpio_out = gpout_reg;
	assign usb_dp_pullup = dp_pullup;
	assign ata_pins_active = ata_act;

	// In input mode, or while ATA pins are inactive, the pin is released; otherwise it shows ATA bus activity.
	assign ata_pullup_ctrl_out = ata_bus_busy;
	assign ata_pullup_ctrl_oe = ~pu_gpin & ata_act; // [RQ1]

	// Configuration clock is pulled low only during startup; data is left released.
	assign i2c_scl_out = 1'b0;
	assign i2c_scl_oe = ~tmr.ready & tmr.scl_low; // [RQ6]
	assign i2c_sda_out = 1'b0;
	assign i2c_sda_oe = 1'b0; // [RQ6]
endmodule // uasi_top
`default_nettype wire

// *** testbench/uasi_monitor.sv ***
/*
 * Concurrent checks on the ports of uasi_top, bound into every instance.
 * Assumes one clock, ref_clk, and the synchronous active-high reset srst.
 */
`timescale 1ns/1ps
`default_nettype none
module uasi_monitor #(
	parameter int STARTUP_CYC = 40
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic service_request_in,
	input wire logic usb_high_speed,
	input wire logic usb_bus_powered,
	input wire logic [5:0] gpio_oe,
	input wire logic i2c_scl_oe,
	input wire logic i2c_sda_oe,
	input wire logic ep1_poll,
	input wire logic ep1_ack,
	input wire logic ep1_nak,
	input wire logic [15:0] ep1_data
);
	int cyc_reg;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	always_ff @(posedge ref_clk) begin
		if (srst) cyc_reg <= 0;
		else if (cyc_reg < STARTUP_CYC + 4) cyc_reg <= cyc_reg + 1;
	end
	a_poll_one_answer: assert property (ep1_poll |=> ep1_ack != ep1_nak)
		else $error("poll not answered once");
	a_no_lone_answer: assert property (!ep1_poll |=> !ep1_ack && !ep1_nak)
		else $error("answer without poll");
	a_pending_cleared: assert property ((ep1_poll && !service_request_in) ##1
		(!service_request_in) [*2] ##1 ep1_poll |=> ep1_nak) else $error("second poll not NAKed");
	a_report_reserved: assert property (ep1_ack |-> ep1_data[15:10] == 6'h00 &&
		ep1_data[7:6] == 2'h0) else $error("reserved report bits set");
	a_report_mode_bits: assert property (ep1_ack |->
		ep1_data[9] == $past(usb_high_speed) && ep1_data[8] == $past(usb_bus_powered))
		else $error("mode bits wrong");
	a_output_gpio_zero: assert property (ep1_ack |->
		(ep1_data[5:0] & $past(gpio_oe) & 6'h3B) == 6'h00) else $error("output pin reported");
	a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state not one cycle");
	a_wait_idle_low: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest without request");
	a_i2c_quiet: assert property (cyc_reg == STARTUP_CYC + 4 |-> !i2c_scl_oe && !i2c_sda_oe)
		else $error("config lines driven after startup");
endmodule // uasi_monitor
bind uasi_top uasi_monitor #(.STARTUP_CYC(STARTUP_CYC)) u_uasi_monitor (.ref_clk(ref_clk),
	.srst(srst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.service_request_in(service_request_in), .usb_high_speed(usb_high_speed),
	.usb_bus_powered(usb_bus_powered), .gpio_oe(gpio_oe), .i2c_scl_oe(i2c_scl_oe),
	.i2c_sda_oe(i2c_sda_oe), .ep1_poll(ep1_poll), .ep1_ack(ep1_ack), .ep1_nak(ep1_nak),
	.ep1_data(ep1_data));
`default_nettype wire

// *** testbench/uasi_host_model.sv ***
/*
 * USB host side of the endpoint 1 interrupt pipe: issues one IN poll on request.
 * Assumes the answer arrives registered in the cycle after the poll edge.
 */
`timescale 1ns/1ps
`default_nettype none
module uasi_host_model (
	input wire logic ref_clk,
	output logic ep1_poll,
	input wire logic ep1_ack,
	input wire logic ep1_nak,
	input wire logic [15:0] ep1_data
);
	initial ep1_poll = 1'b0;
	// The host only polls and takes whatever comes back; it never retries.
	task automatic poll(output logic ack, output logic nak, output logic [15:0] data);
		@(posedge ref_clk);
		ep1_poll <= 1'b1;
		@(posedge ref_clk);
		ep1_poll <= 1'b0;
		@(posedge ref_clk);
		ack = ep1_ack;
		nak = ep1_nak;
		data = ep1_data;
	endtask
endmodule // uasi_host_model
`default_nettype wire

// *** testbench/usb_attach_and_status_interrupt_tb.sv ***
/*
 * Self-checking bench for uasi_top: attach gating, status report, interrupts.
 * Assumes shortened startup and sampling counts set through the top parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_attach_and_status_interrupt_tb;
	localparam int ST = 1100;
	localparam int SP = 100;
	logic ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, en = 1'b0;
	logic drv = 1'b0, hs = 1'b0, bp = 1'b0, sreq = 1'b0, pu_drv = 1'b1, ack, nak;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, rd;
	logic [5:0] gpio_drv = 6'h00;
	logic [15:0] data;
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest, irq, pu_out, pu_oe, pins_act, dp_pu, scl_oe, sda_oe, poll;
	wire logic ep1_ack, ep1_nak;
	wire logic [5:0] gpio_out, gpio_oe, gpio_pin;
	wire logic [15:0] ep1_data;
	int bad_count = 0, check_count = 0, cyc = 0;
	assign gpio_pin = (gpio_oe & gpio_out) | (~gpio_oe & gpio_drv);
	always #5 ref_clk = ~ref_clk;
	uasi_top #(.STARTUP_CYC(ST), .SAMPLE_CYC(SP)) u_uasi_top (.ref_clk(ref_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .bus_power_ata_enable_in(en),
		.ata_drive_detected(drv), .usb_high_speed(hs), .usb_bus_powered(bp),
		.service_request_in(sreq), .ata_bus_busy(1'b0), .gpio_in(gpio_pin), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .ata_pullup_ctrl_in(pu_oe ? pu_out : pu_drv),
		.ata_pullup_ctrl_out(pu_out), .ata_pullup_ctrl_oe(pu_oe), .ata_pins_active(pins_act),
		.usb_dp_pullup(dp_pu), .i2c_scl_in(!scl_oe), .i2c_scl_out(), .i2c_scl_oe(scl_oe),
		.i2c_sda_in(!sda_oe), .i2c_sda_out(), .i2c_sda_oe(sda_oe), .ep1_poll(poll),
		.ep1_ack(ep1_ack), .ep1_nak(ep1_nak), .ep1_data(ep1_data));
	uasi_host_model u_uasi_host_model (.ref_clk(ref_clk), .ep1_poll(poll), .ep1_ack(ep1_ack),
		.ep1_nak(ep1_nak), .ep1_data(ep1_data));
	task automatic summarize();
		if (bad_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic t_reset_values();
		bus(0, uasi_pkg::ADR_CFG8, 0); chk(rd, 32'h0000_0000);
		bus(0, uasi_pkg::ADR_CFG9, 0); chk(rd, 32'h0000_003F);
		bus(0, uasi_pkg::ADR_IRQ_EN, 0); chk(rd, 32'h0000_0000);
		bus(1, uasi_pkg::ADR_REPORT, 32'hFFFF_FFFF);
		bus(0, uasi_pkg::ADR_REPORT, 0); chk(rd, 32'h0000_0000);
		chk(sda_oe, 1'b0);
		chk(scl_oe, 1'b0);
	endtask
	task automatic t_pullup_table();
		logic [3:0] rows [6];
		rows = '{4'hF, 4'hB, 4'hD, 4'h1, 4'h6, 4'h2};
		for (int i = 0; i < 6; i++) begin
			drv <= rows[i][2];
			en <= rows[i][0];
			bus(1, uasi_pkg::ADR_CFG8, {31'h0, rows[i][1]});
			wait_cyc(SP + 4);
			chk(dp_pu, rows[i][3]);
			chk(pins_act, rows[i][0]);
		end
		bus(1, uasi_pkg::ADR_CFG8, 32'h0000_0010);
		wait_cyc(1);
		chk(pins_act, 1'b1);
		chk(pu_oe, 1'b1);
	endtask
	task automatic t_report();
		u_uasi_host_model.poll(ack, nak, data);
		chk({ack, nak}, 2'b01);
		bus(1, uasi_pkg::ADR_CFG9, 32'h0000_0035);
		bus(1, uasi_pkg::ADR_GPOUT, 32'h0000_003F);
		bus(1, uasi_pkg::ADR_IRQ_EN, 32'h0000_0001);
		gpio_drv <= 6'h3F;
		hs <= 1'b1;
		sreq <= 1'b1;
		@(posedge ref_clk) sreq <= 1'b0;
		wait_cyc(2);
		chk(irq, 1'b1);
		chk(gpio_out, 6'h3F);
		chk(gpio_oe, 6'h0A);
		u_uasi_host_model.poll(ack, nak, data);
		chk({ack, nak, data}, {2'b10, 16'h0235});
		u_uasi_host_model.poll(ack, nak, data);
		chk({ack, nak}, 2'b01);
		bus(0, uasi_pkg::ADR_IRQ_ST, 0); chk(rd, 32'h0000_000F);
		bus(1, uasi_pkg::ADR_IRQ_CLR, 32'h0000_000F);
		wait_cyc(1);
		chk(irq, 1'b0);
		bus(1, uasi_pkg::ADR_IRQ_EN, 32'h0000_0000);
		bus(1, uasi_pkg::ADR_CFG9, 32'h0000_003F);
		bus(1, uasi_pkg::ADR_CFG8, 32'h0000_0090);
		pu_drv <= 1'b0;
		hs <= 1'b0;
		bp <= 1'b1;
		sreq <= 1'b1;
		@(posedge ref_clk) sreq <= 1'b0;
		wait_cyc(2);
		chk(irq, 1'b0);
		chk(pu_oe, 1'b0);
		bus(0, uasi_pkg::ADR_IRQ_ST, 0); chk(rd, 32'h0000_0001);
		u_uasi_host_model.poll(ack, nak, data);
		chk({ack, data}, {1'b1, 16'h013B});
		bus(0, uasi_pkg::ADR_REPORT, 0); chk(rd, 32'h0000_013B);
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		wait_cyc(4);
		srst <= 1'b0;
		wait_cyc(uasi_pkg::I2C_HALF_CYC + 100);
		chk(scl_oe, 1'b1);
		chk(sda_oe, 1'b0);
		wait_cyc(ST + 4 - uasi_pkg::I2C_HALF_CYC - 100);
		t_reset_values();
		t_pullup_table();
		t_report();
		summarize();
	end
endmodule // usb_attach_and_status_interrupt_tb
`default_nettype wire
